/* File: hw/load_fifo.sv */
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset; depth a power of two.
*/
`timescale 1ns/1ps
`default_nettype none
module load_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0]   fill;
  } fifo_state_type;

  fifo_state_type   s;
  fifo_state_type   next_s;
  logic [WIDTH-1:0] store [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (s.fill != (AW+1)'(DEPTH));
  assign out_valid = (s.fill != '0);
  assign out_data  = store[s.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wr = s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = s.rd + 1'b1;
    end
    case ({push, pop})
      2'b10:   next_s.fill = s.fill + 1'b1;
      2'b01:   next_s.fill = s.fill - 1'b1;
      default: next_s.fill = s.fill;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Storage needs no reset; empty flag guards stale words
  always_ff @(posedge clock) begin
    if (push) begin
      store[s.wr] <= in_data;
    end
  end
endmodule
`default_nettype wire

/* File: hw/spd_read.sv */
/*
  Read side of a 256-byte presence-detect EEPROM behind a two-wire serial bus:
  current-address, selective and sequential reads, and protection queries.
  Assumes SCL/SDA and address straps arrive asynchronously; SDA is open drain
  and resolved outside. Contents are loaded through a FIFO from the user side.
*/
// Contract
// - protection query is the setting command framed with read/write bit one.
// - ack queries by lock state: permanent none, reversible no lock-query, else all.
// - after a query, the address and data bytes are never acknowledged.
// - idle counter points after the last byte accessed.
// - counter after the top location points at zero.
// - matching read address is acknowledged, then counter byte sent MSB first.
// - dummy write loads the counter; repeated START then reads from there.
// - each master-acknowledged byte advances the counter and sends the next.
// - sequential reads wrap from the last location to the first.
// - stay in power-on reset while the clock line is held low.
// - pulses shorter than about 50 ns on the bus inputs are suppressed.
// - memory access uses prefix 1010b plus three hardware address bits.
// - protection queries use prefix 0110b.
// - no address acknowledge while an internal write cycle runs.
// - 256 bytes as 16 pages of 16; one counter value per byte.
`timescale 1ns/1ps
`default_nettype none
module spd_read
  import spd_read_pkg::*;
#(
  parameter int LOAD_DEPTH = FIFO_DEPTH
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [2:0] address_pins,
  input  wire logic       a0_high_voltage,
  input  wire logic       permanent_lock,
  input  wire logic       reversible_lock,
  input  wire logic       write_busy,
  input  wire logic       load_valid,
  output logic            load_ready,
  input  wire load_type   load_data,
  output logic [7:0]      byte_address,
  output logic            bus_active
);

  link_type s;
  link_type next_s;
  logic [7:0] memory [MEMORY_BYTES];
  logic       drain_valid;
  logic       drain_ready;
  load_type   drain_data;

  // Accept a new level only after it has held for the filter time
  function automatic logic [FILTER_W:0] filter_step(input logic raw, input logic held,
                                                     input logic [FILTER_W-1:0] count);
    logic [FILTER_W:0] r;
    r = {held, count};
    if (raw == held) begin
      r = {held, {FILTER_W{1'b0}}};
    end else if (count >= FILTER_W'(GLITCH_CYCLES)) begin
      r = {raw, {FILTER_W{1'b0}}};
    end else begin
      r = {held, count + 1'b1};
    end
    return r;
  endfunction

  function automatic logic [1:0] decode_address(input logic [7:0] b, input logic [2:0] pins,
                                                input logic hv, input logic busy,
                                                input logic perm, input logic rev);
    logic [1:0] r;
    logic       q_perm;
    logic       q_lock;
    logic       q_unlock;
    r        = ACCESS_NONE;
    q_perm   = !hv && (b[3:1] == pins);
    q_lock   = hv && (b[3:1] == QUERY_LOCK_HW);
    q_unlock = hv && (b[3:1] == QUERY_UNLOCK_HW);
    if (busy) begin
      r = ACCESS_NONE;
    end else if (b[7:4] == MEMORY_PREFIX && b[3:1] == pins) begin
      r = b[0] ? ACCESS_READ : ACCESS_WRITE;
    end else if (b[7:4] == PROTECT_PREFIX && b[0]) begin
      if (!perm && (q_perm || q_unlock || (q_lock && !rev))) begin
        r = ACCESS_QUERY;
      end
    end
    return r;
  endfunction

  // Loading stalls while the serial side is busy, so the FIFO really fills
  assign drain_ready = (s.fsm == ST_IDLE);

  load_fifo #(
    .WIDTH ($bits(load_type)),
    .DEPTH (LOAD_DEPTH)
  ) u_load_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (load_valid),
    .in_ready  (load_ready),
    .in_data   (load_data),
    .out_valid (drain_valid),
    .out_ready (drain_ready),
    .out_data  (drain_data)
  );

  always_ff @(posedge clock) begin
    if (drain_valid && drain_ready) begin
      memory[drain_data.addr] <= drain_data.data;
    end
  end

  always_comb begin
    logic [FILTER_W:0] scl_step;
    logic [FILTER_W:0] sda_step;
    logic              rise;
    logic              fall;
    logic              start;
    logic              stop;
    scl_step = filter_step(s.scl_sync, s.scl_f, s.scl_count);
    sda_step = filter_step(s.sda_sync, s.sda_f, s.sda_count);
    rise  = s.scl_f && !s.scl_prev;
    fall  = !s.scl_f && s.scl_prev;
    start = s.scl_f && s.scl_prev && s.sda_prev && !s.sda_f;
    stop  = s.scl_f && s.scl_prev && !s.sda_prev && s.sda_f;
    next_s = s;
    next_s.pin_meta = {a0_high_voltage, address_pins};
    next_s.pin_sync = s.pin_meta;
    next_s.scl_meta = scl;
    next_s.scl_sync = s.scl_meta;
    next_s.sda_meta = sda_in;
    next_s.sda_sync = s.sda_meta;
    next_s.scl_f     = scl_step[FILTER_W];
    next_s.scl_count = scl_step[FILTER_W-1:0];
    next_s.sda_f     = sda_step[FILTER_W];
    next_s.sda_count = sda_step[FILTER_W-1:0];
    next_s.scl_prev  = s.scl_f;
    next_s.sda_prev  = s.sda_f;

    if (s.por) begin
      next_s.fsm    = ST_IDLE;
      next_s.sda_oe = 1'b0;
      if (s.scl_f) begin
        next_s.por = 1'b0;
      end
    end else if (stop) begin
      next_s.fsm    = ST_IDLE;
      next_s.sda_oe = 1'b0;
    end else if (start) begin
      next_s.fsm       = ST_ADDR;
      next_s.bit_count = 3'h0;
      next_s.sda_oe    = 1'b0;
    end else begin
      case (s.fsm)
        ST_ADDR, ST_WADDR: begin
          if (rise) begin
            next_s.shift     = {s.shift[6:0], s.sda_f};
            next_s.bit_count = s.bit_count + 1'b1;
            if (s.bit_count == 3'h7) begin
              next_s.fsm = (s.fsm == ST_ADDR) ? ST_ADDR_DONE : ST_WADDR_DONE;
            end
          end
        end
        ST_ADDR_DONE: begin
          next_s.access = decode_address(s.shift, s.pin_sync[2:0], s.pin_sync[3],
                                         write_busy, permanent_lock, reversible_lock);
          if (fall) begin
            if (next_s.access != ACCESS_NONE) begin
              next_s.sda_oe = 1'b1;
              next_s.fsm    = ST_ADDR_ACK;
            end else begin
              next_s.fsm = ST_IGNORE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (fall) begin
            next_s.bit_count = 3'h0;
            case (s.access)
              ACCESS_READ: begin
                next_s.shift  = memory[s.counter];
                next_s.sda_oe = !memory[s.counter][7];
                next_s.fsm    = ST_SEND;
              end
              ACCESS_WRITE: begin
                next_s.sda_oe = 1'b0;
                next_s.fsm    = ST_WADDR;
              end
              default: begin
                next_s.sda_oe = 1'b0;
                next_s.fsm    = ST_IGNORE;
              end
            endcase
          end
        end
        ST_WADDR_DONE: begin
          if (fall) begin
            next_s.sda_oe = 1'b1;
            next_s.fsm    = ST_WADDR_ACK;
          end
        end
        ST_WADDR_ACK: begin
          if (fall) begin
            next_s.sda_oe  = 1'b0;
            next_s.counter = s.shift;
            // Data bytes of a write are outside this block and left unanswered
            next_s.fsm     = ST_IGNORE;
          end
        end
        ST_SEND: begin
          if (fall) begin
            if (s.bit_count == 3'h7) begin
              next_s.sda_oe  = 1'b0;
              next_s.counter = s.counter + 8'h01;
              next_s.fsm     = ST_MACK;
            end else begin
              next_s.shift     = {s.shift[6:0], 1'b0};
              next_s.sda_oe    = !s.shift[6];
              next_s.bit_count = s.bit_count + 1'b1;
            end
          end
        end
        ST_MACK: begin
          if (rise) begin
            next_s.master_ack = !s.sda_f;
            next_s.fsm        = ST_MACK_DONE;
          end
        end
        ST_MACK_DONE: begin
          if (fall) begin
            next_s.bit_count = 3'h0;
            if (s.master_ack) begin
              next_s.shift  = memory[s.counter];
              next_s.sda_oe = !memory[s.counter][7];
              next_s.fsm    = ST_SEND;
            end else begin
              next_s.fsm = ST_IGNORE;
            end
          end
        end
        ST_IGNORE: begin
          next_s.sda_oe = 1'b0;
        end
        ST_IDLE: begin
          next_s.sda_oe = 1'b0;
        end
        default: begin
          next_s.fsm    = ST_IDLE;
          next_s.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s          <= '0;
      s.scl_meta <= 1'b0;
      s.sda_meta <= 1'b1;
      s.sda_sync <= 1'b1;
      s.sda_f    <= 1'b1;
      s.sda_prev <= 1'b1;
      s.por      <= 1'b1;
      s.fsm      <= ST_IDLE;
      s.counter  <= COUNTER_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign sda_out      = 1'b0;
  assign sda_oe       = s.sda_oe;
  assign byte_address = s.counter;
  assign bus_active   = (s.fsm != ST_IDLE);

endmodule
`default_nettype wire

/* File: hw/spd_read_pkg.sv */
/*
  Shared constants and types of the presence-detect EEPROM read block:
  slave address prefixes, glitch filter timing, the load record and the
  serial engine state. Assumes a single 10 MHz clock.
*/
package spd_read_pkg;

  localparam int CLOCK_NS      = 100;
  localparam int GLITCH_NS     = 50;
  localparam int GLITCH_RAW    = (GLITCH_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int GLITCH_CYCLES = (GLITCH_RAW < 1) ? 1 : GLITCH_RAW;
  localparam int FILTER_W      = 3;

  localparam int MEMORY_BYTES  = 256;
  localparam int FIFO_DEPTH    = 32;

  localparam logic [3:0] MEMORY_PREFIX   = 4'hA;
  localparam logic [3:0] PROTECT_PREFIX  = 4'h6;
  localparam logic [2:0] QUERY_LOCK_HW   = 3'h0;
  localparam logic [2:0] QUERY_UNLOCK_HW = 3'h2;

  localparam logic [1:0] ACCESS_NONE  = 2'h0;
  localparam logic [1:0] ACCESS_READ  = 2'h1;
  localparam logic [1:0] ACCESS_WRITE = 2'h2;
  localparam logic [1:0] ACCESS_QUERY = 2'h3;

  localparam logic [7:0] COUNTER_RESET = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_ADDR      = 4'b0001,
    ST_ADDR_DONE = 4'b0010,
    ST_ADDR_ACK  = 4'b0011,
    ST_WADDR     = 4'b0100,
    ST_WADDR_DONE= 4'b0101,
    ST_WADDR_ACK = 4'b0110,
    ST_SEND      = 4'b0111,
    ST_MACK      = 4'b1000,
    ST_MACK_DONE = 4'b1001,
    ST_IGNORE    = 4'b1010
  } fsm_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } load_type;

  typedef struct packed {
    logic [3:0]          pin_meta;
    logic [3:0]          pin_sync;
    logic                scl_meta;
    logic                scl_sync;
    logic                sda_meta;
    logic                sda_sync;
    logic [FILTER_W-1:0] scl_count;
    logic [FILTER_W-1:0] sda_count;
    logic                scl_f;
    logic                sda_f;
    logic                scl_prev;
    logic                sda_prev;
    logic                por;
    fsm_type             fsm;
    logic [2:0]          bit_count;
    logic [7:0]          shift;
    logic [7:0]          counter;
    logic [1:0]          access;
    logic                master_ack;
    logic                sda_oe;
  } link_type;

endpackage

/* File: tb/i2c_host.sv */
/*
  Two-wire bus host model: START, STOP and byte transfers, thirteen clocks low and ten clocks high a bit.
  Assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_host (
  input  wire logic clock,
  input  wire logic sda,
  output var logic  scl,
  output var logic  pull
);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Data moves three clocks after the clock falls, so it never races the slave filter
  task automatic start();
    wait_n(3);
    pull = 1'b0;
    wait_n(10);
    scl = 1'b1;
    wait_n(10);
    pull = 1'b1;
    wait_n(10);
    scl = 1'b0;
  endtask
  task automatic stop();
    wait_n(3);
    pull = 1'b1;
    wait_n(10);
    scl = 1'b1;
    wait_n(10);
    pull = 1'b0;
    wait_n(10);
  endtask
  task automatic bit_io(input logic b, output logic r);
    wait_n(3);
    pull = !b;
    wait_n(10);
    scl = 1'b1;
    wait_n(10);
    r = sda;
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic ack_n);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, ack_n);
  endtask
endmodule
`default_nettype wire

/* File: tb/spd_read_props.sv */
/*
  Port checker for the EEPROM read block.
  Assumes it is bound to spd_read from the bench top and sees one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module spd_read_props (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       scl,
  input wire logic       sda_in,
  input wire logic       sda_oe,
  input wire logic       write_busy,
  input wire logic [7:0] byte_address,
  input wire logic       bus_active
);
  logic hold;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Power-on hold lasts until the clock line is first seen high
  always_ff @(posedge clock) begin
    if (!reset_n) hold <= 1'b1;
    else if (scl) hold <= 1'b0;
  end
  property p_por; hold |-> !sda_oe && !bus_active; endproperty
  a_por: assert property (p_por) else $error("bus answered in power-on hold");
  property p_busy; write_busy && $past(write_busy) |-> !$rose(sda_oe); endproperty
  a_busy: assert property (p_busy) else $error("ack while write busy");
  property p_idle; !bus_active && !$past(bus_active) |-> $stable(byte_address); endproperty
  a_idle: assert property (p_idle) else $error("counter moved while idle");
  property p_wrap; $changed(byte_address) && $past(byte_address) == 8'hFF
    |-> byte_address == 8'h00; endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");
  property p_glitch; !bus_active && scl && $fell(sda_in) ##1 sda_in
    |=> !bus_active [*6]; endproperty
  a_glitch: assert property (p_glitch) else $error("spike started a frame");
  property p_ack_low; $rose(sda_oe) |-> !scl && !$past(scl, 2); endproperty
  a_ack_low: assert property (p_ack_low) else $error("data driven in clock high");
  property p_start; $rose(bus_active) |-> scl && !sda_in; endproperty
  a_start: assert property (p_start) else $error("frame without start");
  property p_oe_idle; !bus_active && !$past(bus_active) |-> !sda_oe; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data driven while idle");
endmodule
`default_nettype wire

/* File: tb/tb.sv */
/*
  Self-checking bench: power-on hold, filter, load buffer, queries, reads.
  Assumes the host model and the port checker files.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import spd_read_pkg::*;
  logic       clock;
  logic       reset_n;
  logic       scl_low;
  logic       glitch;
  logic       a0_high_voltage;
  logic       permanent_lock;
  logic       reversible_lock;
  logic       write_busy;
  logic       load_valid;
  load_type   load_data;
  logic [2:0] address_pins;
  logic       host_scl, pull, scl, sda_in, sda_out, sda_oe, load_ready, bus_active, ack_n;
  logic [7:0] byte_address, rd;
  int         fails = 0;
  int         checks_done = 0;
  assign scl = host_scl && !scl_low;
  assign sda_in = !(sda_oe || pull || glitch);
  i2c_host u_host (.clock(clock), .sda(sda_in), .scl(host_scl), .pull(pull));
  spd_read #(.LOAD_DEPTH(4)) u_dut (.clock(clock), .reset_n(reset_n), .scl(scl),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .address_pins(address_pins),
    .a0_high_voltage(a0_high_voltage), .permanent_lock(permanent_lock),
    .reversible_lock(reversible_lock), .write_busy(write_busy), .load_valid(load_valid),
    .load_ready(load_ready), .load_data(load_data), .byte_address(byte_address),
    .bus_active(bus_active));
  initial begin
    clock = 1'b0;
    forever #50 clock = !clock;
  end
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Valid stays high on return so back-to-back loads never toggle it in one step
  task automatic put(input logic [7:0] a);
    load_valid = 1'b1;
    load_data = '{addr: a, data: pat(a)};
    while (!load_ready) u_host.wait_n(1);
    u_host.wait_n(1);
  endtask
  task automatic send(input logic [7:0] a, input logic nack);
    u_host.start();
    u_host.xfer(a, 1'b1, rd, ack_n);
    chk({7'h00, ack_n}, {7'h00, nack});
    u_host.xfer(8'h3C, 1'b1, rd, ack_n);
    chk({7'h00, ack_n}, 8'h01);
    u_host.stop();
  endtask
  task automatic t_por();
    logic seen;
    u_host.wait_n(5);
    glitch = 1'b1;
    u_host.wait_n(12);
    glitch = 1'b0;
    u_host.wait_n(12);
    chk({7'h00, bus_active}, 8'h00);
    scl_low = 1'b0;
    u_host.wait_n(20);
    glitch = 1'b1;
    u_host.wait_n(1);
    glitch = 1'b0;
    // A spike that slips through shows only as a short frame, so watch every cycle
    seen = 1'b0;
    repeat (10) begin
      u_host.wait_n(1);
      seen = seen | bus_active;
    end
    chk({7'h00, seen}, 8'h00);
    chk({7'h00, sda_out}, 8'h00);
    $display("power-on test done");
  endtask
  task automatic t_fill();
    u_host.start();
    put(8'hFE);
    put(8'hFF);
    put(8'h00);
    put(8'h01);
    load_valid = 1'b0;
    chk({7'h00, load_ready}, 8'h00);
    u_host.stop();
    u_host.wait_n(10);
    chk({7'h00, load_ready}, 8'h01);
    $display("load test done");
  endtask
  task automatic t_query();
    for (int s = 0; s < 3; s++) begin
      for (int k = 0; k < 3; k++) begin
        permanent_lock = (s == 0);
        reversible_lock = (s == 1);
        a0_high_voltage = (k != 2);
        send({PROTECT_PREFIX, (k == 0) ? QUERY_LOCK_HW : (k == 1) ? QUERY_UNLOCK_HW
              : address_pins, 1'b1}, !((s == 2) || (s == 1 && k != 0)));
      end
    end
    permanent_lock = 1'b0;
    reversible_lock = 1'b0;
    send({MEMORY_PREFIX, 3'h2, 1'b1}, 1'b1);
    address_pins = 3'h2;
    send({MEMORY_PREFIX, 3'h5, 1'b1}, 1'b1);
    address_pins = 3'h5;
    write_busy = 1'b1;
    send({MEMORY_PREFIX, address_pins, 1'b1}, 1'b1);
    write_busy = 1'b0;
    $display("query test done");
  endtask
  task automatic t_read();
    u_host.start();
    u_host.xfer({MEMORY_PREFIX, address_pins, 1'b0}, 1'b1, rd, ack_n);
    chk({7'h00, ack_n}, 8'h00);
    u_host.xfer(8'hFE, 1'b1, rd, ack_n);
    chk({7'h00, ack_n}, 8'h00);
    u_host.start();
    u_host.xfer({MEMORY_PREFIX, address_pins, 1'b1}, 1'b1, rd, ack_n);
    chk({7'h00, ack_n}, 8'h00);
    for (int i = 0; i < 3; i++) begin
      u_host.xfer(8'hFF, i == 2, rd, ack_n);
      chk(rd, pat(8'hFE + i[7:0]));
    end
    u_host.stop();
    chk(byte_address, 8'h01);
    u_host.start();
    u_host.xfer({MEMORY_PREFIX, address_pins, 1'b1}, 1'b1, rd, ack_n);
    u_host.xfer(8'hFF, 1'b1, rd, ack_n);
    chk(rd, pat(8'h01));
    u_host.stop();
    chk(byte_address, 8'h02);
    $display("read test done");
  endtask
  initial begin
    reset_n         = 1'b0;
    scl_low         = 1'b1;
    glitch          = 1'b0;
    a0_high_voltage = 1'b0;
    permanent_lock  = 1'b0;
    reversible_lock = 1'b0;
    write_busy      = 1'b0;
    load_valid      = 1'b0;
    load_data       = '0;
    address_pins    = 3'h5;
    u_host.wait_n(3);
    reset_n = 1'b1;
    t_por();
    t_fill();
    t_query();
    t_read();
    end_of_test();
  end
  // All tests need under 10000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    end_of_test();
  end
endmodule
bind spd_read spd_read_props u_props (.clock(clock), .reset_n(reset_n), .scl(scl),
  .sda_in(sda_in), .sda_oe(sda_oe), .write_busy(write_busy),
  .byte_address(byte_address), .bus_active(bus_active));
`default_nettype wire
